/* rtl/psirq_top.sv */
// psirq_top: port status, interrupt line, hot-plug and automatic port choice
// assumes: all pins asynchronous to ref_clk, host on the local two-wire port
//
// Functional notes
// R1: in two-wire mode an interrupt is a low-to-high step on the irq line.
// R2: any change of power sense, selected port or its clock detect raises it.
// R3: reading status port_status gives power sense, selected port and clock detect.
// R4: a completed read of status port_status drops the irq line low.
// R5: the host should read status port_status soon after it sees an interrupt.
// R6: in pin-strap mode irq mirrors the selected port's clock detect.
// R7: automatic choice works only in two-wire mode, set by control bits 3 to 5.
// R8: automatic choice uses the two priority bits and the four power sense bits.
// R9: the mode select pin picks two-wire control or pin-strap control.
// R10: the local two-wire port is a target and never starts a transfer.
// R11: the host can set port, edge rate, power state and low-level setting.
// R12: the display-data buffer is enabled per port, only for the chosen one.
// R13: the buffer low level has three settings from the low-level register.
// R14: chosen port hot-plug follows the sink; the others follow power sense (in low power this block drives the chosen one from power sense too).
// R15: the power indicator is high when any power sense input is high.
// R16: a raised irq stays high until the status register is read.
module psirq_top
  import psirq_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       i2c_mode_sel,
  input  wire logic [1:0] port_strap,
  input  wire logic [3:0] source_power_sense,
  input  wire logic [3:0] clock_detect,
  input  wire logic       sink_hotplug_in,
  input  wire logic       low_power_n,
  output logic            irq,
  output logic [3:0]      port_hotplug_out,
  output logic            source_power_indicator,
  output logic [1:0]      selected_port,
  output logic [3:0]      ddc_repeater_en,
  output logic            edge_rate,
  output logic [1:0]      power_mode,
  output logic [1:0]      buffer_low_level_select
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [12:0] pin_a;
  logic [12:0] pin_b;
  logic [7:0]  ctl_reg;
  logic [1:0]  level_reg;
  logic [1:0]  sel_reg;
  logic [3:0]  pwr_prev;
  logic [1:0]  sel_prev;
  logic        cdet_prev;
  logic [7:0]  reg_ptr;
  logic        wr_stb;
  logic [7:0]  wr_data;
  logic        rd_done;
  logic [7:0]  rd_data;
  logic [3:0]  hp_next;
  logic [3:0]  rep_next;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pin_a <= 13'h0000;
      pin_b <= 13'h0000;
    end else begin
      pin_a <= {low_power_n, sink_hotplug_in, clock_detect, source_power_sense,
                port_strap, i2c_mode_sel};
      pin_b <= pin_a;
    end
  end

  wire       i2c_mode = pin_b[0];
  wire [1:0] strap    = pin_b[2:1];
  wire [3:0] pwr      = pin_b[6:3];
  wire [3:0] cdet_all = pin_b[10:7];
  wire       sink_hp  = pin_b[11];
  wire       lp_n     = pin_b[12];

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  psirq_i2c_slave u_slave (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .rd_data (rd_data),
    .reg_ptr (reg_ptr),
    .wr_stb  (wr_stb),
    .wr_data (wr_data),
    .rd_done (rd_done)
  );

  wire       wr_ctl      = wr_stb & (reg_ptr == PSIRQ_CONTROL_OFS);
  wire       wr_level    = wr_stb & (reg_ptr == PSIRQ_LEVEL_OFS);
  wire       status_read = rd_done & (reg_ptr == PSIRQ_STATUS_OFS);
  wire [1:0] ctl_psel    = ctl_reg[PSIRQ_CTL_PSEL_LSB +: 2];
  wire [1:0] ctl_prio    = ctl_reg[PSIRQ_CTL_PRIO_LSB +: 2];
  wire [1:0] ctl_pwr     = ctl_reg[PSIRQ_CTL_PWR_LSB +: 2];
  wire       ctl_auto    = ctl_reg[PSIRQ_CTL_AUTO_BIT];
  wire       cdet        = cdet_all[sel_reg];

  // R3: status layout
  assign rd_data = (reg_ptr == PSIRQ_STATUS_OFS)  ? {1'b0, cdet, sel_reg, pwr} :
                   (reg_ptr == PSIRQ_CONTROL_OFS) ? ctl_reg :
                   (reg_ptr == PSIRQ_LEVEL_OFS)   ? {6'h00, level_reg} : 8'h00;

  // R11: host writable settings
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ctl_reg   <= PSIRQ_CTL_RESET;
      level_reg <= PSIRQ_LEVEL_RESET;
    end else begin
      if (wr_ctl) begin
        ctl_reg <= wr_data;
      end
      if (wr_level) begin
        level_reg <= wr_data[1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // port choice
  // ---------------------------------------------------------------
  function automatic logic [1:0] auto_pick(input logic [1:0] prio, input logic [3:0] p,
                                           input logic [1:0] cur);
    logic [1:0] pick;
    pick = cur;
    for (int i = 3; i >= 0; i--) begin
      if (p[i]) begin
        pick = 2'(i);
      end
    end
    if (p[prio]) begin
      pick = prio;
    end
    return pick;
  endfunction

  // R9: mode pin picks control source
  // R7: automatic choice only in two-wire mode
  // R8: priority port, then lowest powered port
  wire [1:0] sel_next = !i2c_mode ? strap :
                        ctl_auto  ? auto_pick(ctl_prio, pwr, sel_reg) : ctl_psel;

  // ---------------------------------------------------------------
  // interrupt line
  // ---------------------------------------------------------------
  // R2: qualifying changes
  wire change  = (pwr != pwr_prev) | (sel_reg != sel_prev) | (cdet != cdet_prev);
  // R1: raise on change, R4: clear on status read, R16: hold, set wins
  // R6: strap mode mirrors clock detect
  wire irq_next = i2c_mode ? (change | (irq & ~status_read)) : cdet;
  wire lp       = ~lp_n | (ctl_pwr == PSIRQ_PWR_LOW);

  // R14: hot-plug per port
  // R12: buffer enabled only for chosen port
  for (genvar g = 0; g < 4; g++) begin : g_port
    assign hp_next[g]  = (sel_reg == 2'(g) && !lp) ? sink_hp : pwr[g];
    assign rep_next[g] = (sel_reg == 2'(g)) & !lp;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sel_reg                 <= PSIRQ_SEL_RESET;
      pwr_prev                <= 4'h0;
      sel_prev                <= PSIRQ_SEL_RESET;
      cdet_prev               <= 1'b0;
      irq                     <= 1'b0;
      port_hotplug_out        <= 4'h0;
      source_power_indicator  <= 1'b0;
      selected_port           <= PSIRQ_SEL_RESET;
      ddc_repeater_en         <= 4'h0;
      edge_rate               <= 1'b0;
      power_mode              <= PSIRQ_PWR_NORMAL;
      buffer_low_level_select <= PSIRQ_LEVEL_RESET;
    end else begin
      sel_reg                 <= sel_next;
      pwr_prev                <= pwr;
      sel_prev                <= sel_reg;
      cdet_prev               <= cdet;
      irq                     <= irq_next;
      port_hotplug_out        <= hp_next;
      // R15: any power sense high
      source_power_indicator  <= |pwr;
      selected_port           <= sel_reg;
      ddc_repeater_en         <= rep_next;
      edge_rate               <= ctl_reg[PSIRQ_CTL_EDGE_BIT];
      power_mode              <= lp ? PSIRQ_PWR_LOW : (i2c_mode ? ctl_pwr : PSIRQ_PWR_NORMAL);
      // R13: low-level setting to buffer
      buffer_low_level_select <= level_reg;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_irq_raise;
    i2c_mode && change |=> irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("irq not raised on change"); // R1 R2

  property p_irq_hold;
    i2c_mode && irq && !status_read ##1 i2c_mode |-> irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped before read"); // R16

  property p_irq_clear;
    i2c_mode && irq && status_read && !change |=> !irq;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq not cleared by read"); // R4

  property p_gpio_irq;
    !i2c_mode |=> irq == $past(cdet);
  endproperty
  a_gpio_irq: assert property (p_gpio_irq) else $error("irq not mirroring clock detect"); // R6

  property p_strap_sel;
    !i2c_mode ##1 !i2c_mode |=> selected_port == $past(strap, 2);
  endproperty
  a_strap_sel: assert property (p_strap_sel) else $error("strap port not applied"); // R9

  property p_auto_prio;
    i2c_mode && ctl_auto && pwr[ctl_prio] |=> sel_reg == $past(ctl_prio);
  endproperty
  a_auto_prio: assert property (p_auto_prio) else $error("priority port not chosen"); // R8

  property p_manual;
    i2c_mode && !ctl_auto |=> sel_reg == $past(ctl_psel);
  endproperty
  a_manual: assert property (p_manual) else $error("manual port not chosen"); // R7

  property p_ctl_write;
    wr_ctl |=> ##1 edge_rate == $past(wr_data[PSIRQ_CTL_EDGE_BIT], 2);
  endproperty
  a_ctl_write: assert property (p_ctl_write) else $error("edge rate not written"); // R11

  property p_indicator;
    ##1 source_power_indicator == $past(|pwr);
  endproperty
  a_indicator: assert property (p_indicator) else $error("power indicator wrong"); // R15

  property p_hotplug;
    !lp |=> port_hotplug_out[$past(sel_reg)] == $past(sink_hp);
  endproperty
  a_hotplug: assert property (p_hotplug) else $error("chosen hot-plug not following sink"); // R14

  property p_repeater;
    $onehot0(ddc_repeater_en);
  endproperty
  a_repeater: assert property (p_repeater) else $error("more than one buffer enabled"); // R12

  c_irq_cycle: cover property (i2c_mode && change ##[1:500] status_read ##1 !irq);
  c_auto_pick: cover property (i2c_mode && ctl_auto && (sel_next != sel_reg));
  c_gpio_irq:  cover property (!i2c_mode && $rose(irq));

endmodule

/* rtl/psirq_pkg.sv */
// psirq_pkg: shared constants for the port status, interrupt and auto-select block
// assumes: one 10 MHz clock, synchronous active-low reset
package psirq_pkg;

  // ---------------------------------------------------------------
  // register offsets on the local two-wire port
  // ---------------------------------------------------------------
  localparam logic [7:0] PSIRQ_STATUS_OFS  = 8'h01;
  localparam logic [7:0] PSIRQ_CONTROL_OFS = 8'h02;
  localparam logic [7:0] PSIRQ_LEVEL_OFS   = 8'h03;

  // slave address, value is arbitrary
  localparam logic [6:0] PSIRQ_SLAVE_ADDR  = 7'h2c;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int PSIRQ_CTL_PSEL_LSB = 0;
  localparam int PSIRQ_CTL_EDGE_BIT = 2;
  localparam int PSIRQ_CTL_PRIO_LSB = 3;
  localparam int PSIRQ_CTL_AUTO_BIT = 5;
  localparam int PSIRQ_CTL_PWR_LSB  = 6;

  localparam logic [1:0] PSIRQ_PWR_NORMAL  = 2'h0;
  localparam logic [1:0] PSIRQ_PWR_STANDBY = 2'h1;
  localparam logic [1:0] PSIRQ_PWR_LOW     = 2'h2;

  // ---------------------------------------------------------------
  // status register fields
  // ---------------------------------------------------------------
  localparam int PSIRQ_STAT_PWR_LSB = 0;
  localparam int PSIRQ_STAT_SEL_LSB = 4;
  localparam int PSIRQ_STAT_CDET_BIT = 6;

  // ---------------------------------------------------------------
  // values after reset, and the bit count of a full byte
  // ---------------------------------------------------------------
  localparam logic [7:0] PSIRQ_CTL_RESET   = 8'h00;
  localparam logic [1:0] PSIRQ_LEVEL_RESET = 2'h0;
  localparam logic [1:0] PSIRQ_SEL_RESET   = 2'h0;
  localparam logic [3:0] PSIRQ_BIT_CNT_MAX = 4'h8;

  // ---------------------------------------------------------------
  // two-wire slave states
  // ---------------------------------------------------------------
  typedef enum logic [8:0] {
    PSIRQ_ST_IDLE  = 9'h001,
    PSIRQ_ST_ADDR  = 9'h002,
    PSIRQ_ST_ACK_A = 9'h004,
    PSIRQ_ST_PTR   = 9'h008,
    PSIRQ_ST_ACK_P = 9'h010,
    PSIRQ_ST_WDATA = 9'h020,
    PSIRQ_ST_ACK_W = 9'h040,
    PSIRQ_ST_RDATA = 9'h080,
    PSIRQ_ST_RACK  = 9'h100
  } psirq_i2c_state_t;

endpackage

/* rtl/psirq_i2c_slave.sv */
// psirq_i2c_slave: target-only two-wire port with a register pointer
// assumes: scl/sda arrive from pins, read data supplied by the parent
module psirq_i2c_slave
  import psirq_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [7:0] rd_data,
  output logic      [7:0] reg_ptr,
  output logic            wr_stb,
  output logic      [7:0] wr_data,
  output logic            rd_done
);

  // ---------------------------------------------------------------
  // pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [1:0]       scl_sync;
  logic [1:0]       sda_sync;
  logic             scl_d;
  logic             sda_d;
  psirq_i2c_state_t state;
  logic [3:0]       cnt;
  logic [7:0]       sr;
  logic [7:0]       tx;
  logic             rw;
  logic             nack;

  wire scl_s    = scl_sync[1];
  wire sda_s    = sda_sync[1];
  wire start_w  = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_w   = scl_s & scl_d & ~sda_d & sda_s;
  wire rise_w   = scl_s & ~scl_d;
  wire fall_w   = ~scl_s & scl_d;
  wire byte_w   = (cnt == PSIRQ_BIT_CNT_MAX);
  wire addr_hit = (sr[7:1] == PSIRQ_SLAVE_ADDR);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_d    <= scl_s;
      sda_d    <= sda_s;
    end
  end

  // ---------------------------------------------------------------
  // byte engine
  // ---------------------------------------------------------------
  // R10: target only, drives sda low for ack and data
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state   <= PSIRQ_ST_IDLE;
      cnt     <= 4'h0;
      sr      <= 8'h00;
      tx      <= 8'h00;
      rw      <= 1'b0;
      nack    <= 1'b0;
      reg_ptr <= 8'h00;
      wr_stb  <= 1'b0;
      wr_data <= 8'h00;
      rd_done <= 1'b0;
      sda_oe  <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      wr_stb  <= 1'b0;
      rd_done <= 1'b0;
      if (rd_done) begin
        reg_ptr <= reg_ptr + 8'h01;
      end
      if (start_w) begin
        state  <= PSIRQ_ST_ADDR;
        cnt    <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_w) begin
        state  <= PSIRQ_ST_IDLE;
        sda_oe <= 1'b0;
      end else if (rise_w) begin
        case (state)
          PSIRQ_ST_ADDR, PSIRQ_ST_PTR, PSIRQ_ST_WDATA: begin
            sr  <= {sr[6:0], sda_s};
            cnt <= cnt + 4'h1;
          end
          PSIRQ_ST_RACK: begin
            nack    <= sda_s;
            rd_done <= 1'b1;
          end
          default: begin
          end
        endcase
      end else if (fall_w) begin
        case (state)
          PSIRQ_ST_ADDR: begin
            if (byte_w) begin
              state  <= addr_hit ? PSIRQ_ST_ACK_A : PSIRQ_ST_IDLE;
              sda_oe <= addr_hit;
              rw     <= sr[0];
            end
          end
          PSIRQ_ST_PTR: begin
            if (byte_w) begin
              reg_ptr <= sr;
              state   <= PSIRQ_ST_ACK_P;
              sda_oe  <= 1'b1;
            end
          end
          PSIRQ_ST_WDATA: begin
            if (byte_w) begin
              wr_stb  <= 1'b1;
              wr_data <= sr;
              state   <= PSIRQ_ST_ACK_W;
              sda_oe  <= 1'b1;
            end
          end
          PSIRQ_ST_ACK_A, PSIRQ_ST_RACK: begin
            if (state == PSIRQ_ST_RACK && nack) begin
              state  <= PSIRQ_ST_IDLE;
              sda_oe <= 1'b0;
            end else if (state == PSIRQ_ST_RACK || rw) begin
              state  <= PSIRQ_ST_RDATA;
              tx     <= {rd_data[6:0], 1'b0};
              sda_oe <= ~rd_data[7];
              cnt    <= 4'h1;
            end else begin
              state  <= PSIRQ_ST_PTR;
              sda_oe <= 1'b0;
              cnt    <= 4'h0;
            end
          end
          PSIRQ_ST_ACK_P, PSIRQ_ST_ACK_W: begin
            if (state == PSIRQ_ST_ACK_W) begin
              reg_ptr <= reg_ptr + 8'h01;
            end
            state  <= PSIRQ_ST_WDATA;
            sda_oe <= 1'b0;
            cnt    <= 4'h0;
          end
          PSIRQ_ST_RDATA: begin
            if (byte_w) begin
              state  <= PSIRQ_ST_RACK;
              sda_oe <= 1'b0;
            end else begin
              sda_oe <= ~tx[7];
              tx     <= {tx[6:0], 1'b0};
              cnt    <= cnt + 4'h1;
            end
          end
          default: begin
            state <= PSIRQ_ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

/* verification/psirq_host_model.sv */
// psirq_host_model: sink-side controller driving the local two-wire port
// assumes: open-drain data line resolved by the bench, pull-up when released
module psirq_host_model
  import psirq_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  // quarter of a 100 kHz bit period, in ref_clk cycles
  localparam int QTR = 25;

  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wq(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // --------------------------------------------------------------
  // framing
  // --------------------------------------------------------------
  // host starts every transfer
  task automatic start_c;
    sda_low <= 1'b0;
    wq(QTR);
    scl <= 1'b1;
    wq(QTR);
    sda_low <= 1'b1;
    wq(QTR);
    scl <= 1'b0;
    wq(QTR);
  endtask

  task automatic stop_c;
    sda_low <= 1'b1;
    wq(QTR);
    scl <= 1'b1;
    wq(QTR);
    sda_low <= 1'b0;
    wq(2 * QTR);
  endtask

  // one bit: data set while scl low, sampled mid-high
  task automatic bit_c(input logic b, output logic s);
    sda_low <= ~b;
    wq(QTR);
    scl <= 1'b1;
    wq(QTR);
    s = sda_line;
    wq(QTR);
    scl <= 1'b0;
    wq(QTR);
  endtask

  // eight bits msb first, then the ninth bit given by mbit
  task automatic byte_c(input logic [7:0] d, input logic mbit, output logic [7:0] q,
                        output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(d[i], s);
      q[i] = s;
    end
    bit_c(mbit, s);
    ack = ~s;
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       a1, a2, a3;
    start_c();
    byte_c({PSIRQ_SLAVE_ADDR, 1'b0}, 1'b1, q, a1);
    byte_c(ptr, 1'b1, q, a2);
    byte_c(d, 1'b1, q, a3);
    stop_c();
    ok = a1 & a2 & a3;
  endtask

  // pointer write, repeated start, one byte read, nack
  task automatic rd(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       a1, a2, a3, n;
    start_c();
    byte_c({PSIRQ_SLAVE_ADDR, 1'b0}, 1'b1, q, a1);
    byte_c(ptr, 1'b1, q, a2);
    start_c();
    byte_c({PSIRQ_SLAVE_ADDR, 1'b1}, 1'b1, q, a3);
    byte_c(8'hff, 1'b1, d, n);
    stop_c();
    ok = a1 & a2 & a3;
  endtask
endmodule

/* verification/psirq_top_tb.sv */
// psirq_top_tb: register, interrupt, port choice and hot-plug tests
// assumes: host model on the two-wire port, all other pins driven here
module psirq_top_tb
  import psirq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic       ref_clk, reset_n, i2c_mode_sel, sink_hotplug_in, low_power_n;
  logic [1:0] port_strap, selected_port, power_mode, buffer_low_level_select;
  logic [3:0] source_power_sense, clock_detect, port_hotplug_out, ddc_repeater_en;
  logic       sda_out, sda_oe, irq, source_power_indicator, edge_rate;
  logic       scl, sda_low;
  wire logic  sda_line;
  int         n_fail, check_count;
  logic [7:0] q;
  logic       ok;

  assign sda_line = ~(sda_low | sda_oe);

  psirq_top DUT (
    .ref_clk(ref_clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .i2c_mode_sel(i2c_mode_sel),
    .port_strap(port_strap), .source_power_sense(source_power_sense),
    .clock_detect(clock_detect), .sink_hotplug_in(sink_hotplug_in),
    .low_power_n(low_power_n), .irq(irq), .port_hotplug_out(port_hotplug_out),
    .source_power_indicator(source_power_indicator), .selected_port(selected_port),
    .ddc_repeater_en(ddc_repeater_en), .edge_rate(edge_rate), .power_mode(power_mode),
    .buffer_low_level_select(buffer_low_level_select)
  );

  psirq_host_model host (
    .ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low)
  );

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic settle;
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    host.wr(ptr, d, ok);
    chk({7'h0, ok}, 8'h01);
  endtask

  task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp);
    host.rd(ptr, q, ok);
    chk({7'h0, ok}, 8'h01);
    chk(q, exp);
  endtask

  task automatic wait_irq(input logic v);
    for (int i = 0; i < 40 && irq !== v; i++) @(posedge ref_clk);
    chk({7'h0, irq}, {7'h0, v});
    if (irq !== v) finish_test();
  endtask

  function automatic logic [7:0] st(input logic [1:0] s);
    return {1'b0, clock_detect[s], s, source_power_sense};
  endfunction

  task automatic check_out(input logic [1:0] sel, input logic lp);
    logic [3:0] hp;
    settle();
    hp = source_power_sense;
    if (!lp) hp[sel] = sink_hotplug_in;
    chk({6'h0, selected_port}, {6'h0, sel});
    chk({4'h0, port_hotplug_out}, {4'h0, hp});
    chk({7'h0, source_power_indicator}, {7'h0, |source_power_sense});
    chk({4'h0, ddc_repeater_en}, lp ? 8'h00 : (8'h01 << sel));
  endtask

  // raise seen, a second change keeps it, status read drops it
  task automatic irq_round(input logic [1:0] sel);
    wait_irq(1'b1);
    @(posedge ref_clk);
    source_power_sense <= source_power_sense ^ 4'h8;
    settle();
    chk({7'h0, irq}, 8'h01);
    rd_chk(PSIRQ_STATUS_OFS, st(sel));
    wait_irq(1'b0);
  endtask

  initial begin
    repeat (90000) @(posedge ref_clk);
    n_fail++;
    finish_test();
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    n_fail = 0;
    check_count = 0;
    reset_n = 1'b0;
    i2c_mode_sel = 1'b1;
    port_strap = 2'h0;
    source_power_sense = 4'h0;
    clock_detect = 4'h0;
    sink_hotplug_in = 1'b1;
    low_power_n = 1'b1;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk({5'h0, sda_out, irq, sda_oe}, 8'h00);
    repeat (6) @(posedge ref_clk);

    wr(PSIRQ_CONTROL_OFS, 8'h46);
    rd_chk(PSIRQ_CONTROL_OFS, 8'h46);
    chk({5'h0, edge_rate, power_mode}, {5'h0, 1'b1, PSIRQ_PWR_STANDBY});
    check_out(2'h2, 1'b0);
    for (int lv = 0; lv < 3; lv++) begin
      wr(PSIRQ_LEVEL_OFS, lv[7:0]);
      settle();
      chk({6'h0, buffer_low_level_select}, lv[7:0]);
    end
    rd_chk(8'h07, 8'h00);
    wr(PSIRQ_STATUS_OFS, 8'hff);
    rd_chk(PSIRQ_STATUS_OFS, st(2'h2));
    wr(PSIRQ_CONTROL_OFS, 8'h80);
    chk({5'h0, edge_rate, power_mode}, {5'h0, 1'b0, PSIRQ_PWR_LOW});
    check_out(2'h0, 1'b1);
    $display("test registers done");

    wr(PSIRQ_CONTROL_OFS, 8'h01);
    rd_chk(PSIRQ_STATUS_OFS, st(2'h1));
    wait_irq(1'b0);
    @(posedge ref_clk);
    clock_detect <= 4'h4;
    settle();
    chk({7'h0, irq}, 8'h00);
    source_power_sense <= 4'h5;
    irq_round(2'h1);
    clock_detect <= 4'h6;
    irq_round(2'h1);
    wr(PSIRQ_CONTROL_OFS, 8'h03);
    irq_round(2'h3);
    check_out(2'h3, 1'b0);
    $display("test interrupt done");

    @(posedge ref_clk);
    source_power_sense <= 4'h4;
    wr(PSIRQ_CONTROL_OFS, 8'h30);
    check_out(2'h2, 1'b0);
    source_power_sense <= 4'ha;
    check_out(2'h1, 1'b0);
    source_power_sense <= 4'h0;
    check_out(2'h1, 1'b0);
    source_power_sense <= 4'hf;
    for (int p = 0; p < 4; p++) begin
      wr(PSIRQ_CONTROL_OFS, 8'h20 | (p[7:0] << 3));
      check_out(p[1:0], 1'b0);
    end
    i2c_mode_sel <= 1'b0;
    port_strap <= 2'h1;
    clock_detect <= 4'h0;
    check_out(2'h1, 1'b0);
    $display("test autochoice done");

    wait_irq(1'b0);
    clock_detect <= 4'h2;
    wait_irq(1'b1);
    clock_detect <= 4'hd;
    wait_irq(1'b0);
    low_power_n <= 1'b0;
    check_out(2'h1, 1'b1);
    chk({6'h0, power_mode}, {6'h0, PSIRQ_PWR_LOW});
    low_power_n <= 1'b1;
    check_out(2'h1, 1'b0);
    chk({6'h0, power_mode}, {6'h0, PSIRQ_PWR_NORMAL});
    $display("test pinstrap done");
    finish_test();
  end
endmodule
